// [rtl/uart_regs.svh]
// Register addresses, field positions, reset values and timing constants
// Assumes inclusion by bare name from the design
`ifndef UART_REGS_SVH
`define UART_REGS_SVH

// ----------------------------------------------------------------------------
// Register addresses (A2..A0)
// ----------------------------------------------------------------------------
`define ADDR_DATA    3'h0
`define ADDR_MASK    3'h1
`define ADDR_SOURCE  3'h2
`define ADDR_FORMAT  3'h3
`define ADDR_MODEM   3'h4
`define ADDR_LINE    3'h5
`define ADDR_MSTATE  3'h6
`define ADDR_SCRATCH 3'h7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FMT_STOP     2
`define FMT_PAR_EN   3
`define FMT_EVEN     4
`define FMT_STICK    5
`define FMT_BREAK    6
`define FMT_DLAB     7
`define MC_DTR       0
`define MC_RTS       1
`define MC_RING      2
`define MC_OUT2      3
`define MC_LOOP      4

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define RST_BYTE     8'h00
`define RST_DIV      16'h0001
`define SRC_LINE     4'h6
`define SRC_RX       4'h4
`define SRC_TX       4'h2
`define SRC_MODEM    4'h0
`define SRC_NONE     4'h1

// ----------------------------------------------------------------------------
// Timing in 16x ticks
// ----------------------------------------------------------------------------
`define TICKS_BIT    4'hf
`define TICKS_HALF   4'h7
`define TICKS_HALFST 5'h07
`define TICKS_FULLST 5'h0f
`define TICKS_ONEHALF 5'h17
`define TICKS_TWOST  5'h1f

`endif

// [rtl/uart_pkg.sv]
// Types shared by the serial channel
// Assumes the register header is included beside it
package uart_pkg;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP   = 3'b100
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } rx_state_t;

endpackage

// [rtl/uart_line_and_modem_control.sv]
// One asynchronous serial channel with line and modem control registers
// Assumes a CPU on a synchronous strobed register port and a 100 MHz clock
//
// Contract
// - Source code shows highest pending interrupt
// - Bit 0 low when pending; upper zero
// - Format bits 1:0 choose five to eight
// - Stop bits: one, one-and-half, or two
// - Bit 3 adds and checks parity
// - Bit 4 picks odd or even parity
// - Bit 5 forces parity constant
// - Bit 6 holds transmit line low
// - Bit 7 maps divisor latch instead
// - Modem bits drive terminal-ready, request-to-send
// - Ring control feeds ring in loopback
// - Out bit enables interrupt, carrier loopback
// - Modem bit 4 enables local loopback
// - Data ready while holding register full
// - Overrun sets flag, holding kept
// - Parity mismatch sets parity error
// - Missing stop bit sets framing error
// - Line low whole frame sets break
// - Holding empty flag raises transmit interrupt
// - Shift-empty flag needs both registers empty
// - Modem change bits set, read clears
// - Ring change only on rising edge
// - Source read clears transmit interrupt only, when reported
// - Mask bits enable four sources
// - Start validated at mid-bit sample
// - Loopback status bits mirror modem control
`timescale 1ns/1ps
`include "uart_regs.svh"

module uart_line_and_modem_control #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [2:0]        addr,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata,
  // Serial line
  input  wire logic              rx_in,
  output logic                   tx_out,
  // Modem inputs
  input  wire logic              clear_to_send_n,
  input  wire logic              data_set_ready_n,
  input  wire logic              ring_indicate_n,
  input  wire logic              carrier_detect_n,
  // Modem outputs
  output logic                   terminal_ready_n,
  output logic                   request_to_send_n,
  // Interrupt pin, oe low while driven
  output logic                   irq_out,
  output logic                   irq_oe_n
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0]  line_format_reg_q;
  logic [7:0]  modem_line_control_reg_q;
  logic [3:0]  interrupt_mask_reg_q;
  logic [7:0]  scratch_q;
  logic [15:0] divisor_q;
  logic [7:0]  tx_holding_reg_q;
  logic [7:0]  rx_holding_reg_q;
  logic        rx_char_waiting_q;
  logic        tx_space_free_q;
  logic        overrun_q, parity_err_q, framing_err_q, break_q;
  logic [3:0]  delta_q;
  logic [3:0]  modem_prev_q;
  logic        tx_irq_q;
  logic        loop;
  logic        dlab;

  assign loop = modem_line_control_reg_q[`MC_LOOP];
  assign dlab = line_format_reg_q[`FMT_DLAB];

  logic wr_data, rd_data, rd_src, rd_line, rd_mstate;
  assign wr_data   = wr_en && addr == `ADDR_DATA && !dlab;
  assign rd_data   = rd_en && addr == `ADDR_DATA && !dlab;
  assign rd_src    = rd_en && addr == `ADDR_SOURCE;
  assign rd_line   = rd_en && addr == `ADDR_LINE;
  assign rd_mstate = rd_en && addr == `ADDR_MSTATE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_format_reg_q        <= `RST_BYTE;
      modem_line_control_reg_q <= `RST_BYTE;
      interrupt_mask_reg_q     <= 4'h0;
      scratch_q                <= `RST_BYTE;
      divisor_q                <= `RST_DIV;
    end else if (wr_en) begin
      case (addr)
        `ADDR_DATA:    if (dlab) divisor_q[7:0] <= wdata;
        `ADDR_MASK:    if (dlab) divisor_q[15:8] <= wdata;
                       else interrupt_mask_reg_q <= wdata[3:0];
        `ADDR_FORMAT:  line_format_reg_q <= wdata;
        `ADDR_MODEM:   modem_line_control_reg_q <= {3'h0, wdata[4:0]};
        `ADDR_SCRATCH: scratch_q <= wdata;
        default:       ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Baud tick, 16x rate
  // --------------------------------------------------------------------------
  logic [15:0] baud_cnt_q;
  logic        tick;
  assign tick = baud_cnt_q == 16'h0000;
  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      baud_cnt_q <= (rst_n && divisor_q != 16'h0000) ? divisor_q - 16'h0001 : 16'h0000;
    end else begin
      baud_cnt_q <= baud_cnt_q - 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Format decode
  // --------------------------------------------------------------------------
  logic [2:0] last_bit;
  logic [4:0] stop_ticks;
  assign last_bit   = {1'b1, line_format_reg_q[1:0]};
  assign stop_ticks = !line_format_reg_q[`FMT_STOP] ? `TICKS_FULLST
                    : (line_format_reg_q[1:0] == 2'b00 ? `TICKS_ONEHALF : `TICKS_TWOST);

  function automatic logic par_of(input logic [7:0] d, input logic [7:0] fmt);
    logic [7:0] m;
    m = 8'hff >> (3'h3 - {1'b0, fmt[1:0]});
    if (fmt[`FMT_STICK]) par_of = !fmt[`FMT_EVEN];
    else par_of = ^(d & m) ^ !fmt[`FMT_EVEN];
  endfunction

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  uart_pkg::tx_state_t tx_state_q;
  logic [7:0] tx_shift_q;
  logic [3:0] tx_tick_q;
  logic [4:0] tx_stop_q;
  logic [2:0] tx_bit_q;
  logic       tx_line_q;
  logic       tx_par_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_state_q <= uart_pkg::TX_IDLE;
      tx_shift_q <= `RST_BYTE;
      tx_tick_q  <= 4'h0;
      tx_stop_q  <= 5'h00;
      tx_bit_q   <= 3'h0;
      tx_line_q  <= 1'b1;
      tx_par_q   <= 1'b0;
    end else begin
      case (tx_state_q)
        uart_pkg::TX_IDLE: if (!tx_space_free_q && tick) begin
          tx_state_q <= uart_pkg::TX_START;
          tx_shift_q <= tx_holding_reg_q;
          tx_par_q   <= par_of(tx_holding_reg_q, line_format_reg_q);
          tx_line_q  <= 1'b0;
          tx_tick_q  <= 4'h0;
        end
        uart_pkg::TX_START: if (tick) begin
          tx_tick_q <= tx_tick_q + 4'h1;
          if (tx_tick_q == `TICKS_BIT) begin
            tx_state_q <= uart_pkg::TX_DATA;
            tx_line_q  <= tx_shift_q[0];
            tx_bit_q   <= 3'h0;
          end
        end
        uart_pkg::TX_DATA: if (tick) begin
          tx_tick_q <= tx_tick_q + 4'h1;
          if (tx_tick_q == `TICKS_BIT) begin
            if (tx_bit_q == last_bit) begin
              tx_state_q <= line_format_reg_q[`FMT_PAR_EN] ? uart_pkg::TX_PARITY
                                                           : uart_pkg::TX_STOP;
              tx_line_q  <= line_format_reg_q[`FMT_PAR_EN] ? tx_par_q : 1'b1;
              tx_stop_q  <= 5'h00;
            end else begin
              tx_bit_q   <= tx_bit_q + 3'h1;
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
              tx_line_q  <= tx_shift_q[1];
            end
          end
        end
        uart_pkg::TX_PARITY: if (tick) begin
          tx_tick_q <= tx_tick_q + 4'h1;
          if (tx_tick_q == `TICKS_BIT) begin
            tx_state_q <= uart_pkg::TX_STOP;
            tx_line_q  <= 1'b1;
            tx_stop_q  <= 5'h00;
          end
        end
        uart_pkg::TX_STOP: if (tick) begin
          tx_stop_q <= tx_stop_q + 5'h01;
          if (tx_stop_q == stop_ticks) tx_state_q <= uart_pkg::TX_IDLE;
        end
        default: tx_state_q <= uart_pkg::TX_IDLE;
      endcase
    end
  end

  // Holding register and empty flag
  logic tx_load;
  assign tx_load = tx_state_q == uart_pkg::TX_IDLE && !tx_space_free_q && tick;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_holding_reg_q <= `RST_BYTE;
      tx_space_free_q  <= 1'b1;
    end else if (wr_data) begin
      tx_holding_reg_q <= wdata;
      tx_space_free_q  <= 1'b0;
    end else if (tx_load) begin
      tx_space_free_q  <= 1'b1;
    end
  end

  // Transmit interrupt: set on empty, cleared by source read or data write
  logic tx_irq_clr;
  always_ff @(posedge clk) begin
    if (!rst_n) tx_irq_q <= 1'b0;
    else if (tx_load) tx_irq_q <= 1'b1;
    else if (wr_data || tx_irq_clr) tx_irq_q <= 1'b0;
  end

  // Pin outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_out            <= 1'b1;
      terminal_ready_n  <= 1'b1;
      request_to_send_n <= 1'b1;
    end else begin
      tx_out <= loop ? 1'b1
              : (line_format_reg_q[`FMT_BREAK] ? 1'b0 : tx_line_q);
      terminal_ready_n  <= loop | !modem_line_control_reg_q[`MC_DTR];
      request_to_send_n <= loop | !modem_line_control_reg_q[`MC_RTS];
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  uart_pkg::rx_state_t rx_state_q;
  logic       rx_line;
  logic       rx_prev_q;
  logic [7:0] rx_shift_q;
  logic [3:0] rx_tick_q;
  logic [2:0] rx_bit_q;
  logic       rx_zero_q;
  logic       rx_perr_q;
  logic       rx_done;
  logic       rx_ferr, rx_brk;
  assign rx_line = loop ? (line_format_reg_q[`FMT_BREAK] ? 1'b0 : tx_line_q) : rx_in;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_state_q <= uart_pkg::RX_IDLE;
      rx_prev_q  <= 1'b1;
      rx_shift_q <= `RST_BYTE;
      rx_tick_q  <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_zero_q  <= 1'b0;
      rx_perr_q  <= 1'b0;
    end else if (tick) begin
      rx_prev_q <= rx_line;
      case (rx_state_q)
        uart_pkg::RX_IDLE: if (rx_prev_q && !rx_line) begin
          rx_state_q <= uart_pkg::RX_START;
          rx_tick_q  <= 4'h0;
        end
        uart_pkg::RX_START: begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == `TICKS_HALF) begin
            rx_tick_q  <= 4'h0;
            rx_state_q <= rx_line ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
            rx_bit_q   <= 3'h0;
            rx_shift_q <= `RST_BYTE;
            rx_zero_q  <= 1'b1;
          end
        end
        uart_pkg::RX_DATA: begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == `TICKS_BIT) begin
            rx_shift_q[rx_bit_q] <= rx_line;
            rx_zero_q <= rx_zero_q & !rx_line;
            rx_bit_q  <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) begin
              rx_state_q <= line_format_reg_q[`FMT_PAR_EN] ? uart_pkg::RX_PARITY
                                                           : uart_pkg::RX_STOP;
              rx_perr_q  <= 1'b0;
            end
          end
        end
        uart_pkg::RX_PARITY: begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == `TICKS_BIT) begin
            rx_perr_q  <= rx_line != par_of(rx_shift_q, line_format_reg_q);
            rx_zero_q  <= rx_zero_q & !rx_line;
            rx_state_q <= uart_pkg::RX_STOP;
          end
        end
        uart_pkg::RX_STOP: begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == `TICKS_BIT) rx_state_q <= uart_pkg::RX_IDLE;
        end
        default: rx_state_q <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  assign rx_done = tick && rx_state_q == uart_pkg::RX_STOP && rx_tick_q == `TICKS_BIT;
  assign rx_ferr = !rx_line;
  assign rx_brk  = rx_zero_q && !rx_line;

  // Holding register and line status flags; set wins over read clear
  logic line_clr;
  assign line_clr = rd_line;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_holding_reg_q  <= `RST_BYTE;
      rx_char_waiting_q <= 1'b0;
      overrun_q         <= 1'b0;
      parity_err_q      <= 1'b0;
      framing_err_q     <= 1'b0;
      break_q           <= 1'b0;
    end else begin
      if (rx_done && !rx_char_waiting_q) begin
        rx_holding_reg_q  <= rx_shift_q;
        rx_char_waiting_q <= 1'b1;
      end else if (rd_data) begin
        rx_char_waiting_q <= 1'b0;
      end
      overrun_q     <= (rx_done && rx_char_waiting_q) || (overrun_q && !line_clr);
      parity_err_q  <= (rx_done && rx_perr_q) || (parity_err_q && !line_clr);
      framing_err_q <= (rx_done && rx_ferr) || (framing_err_q && !line_clr);
      break_q       <= (rx_done && rx_brk) || (break_q && !line_clr);
    end
  end

  // --------------------------------------------------------------------------
  // Modem status
  // --------------------------------------------------------------------------
  logic [3:0] modem_now;
  // Order: cts, dsr, ri, cd as active-high levels
  assign modem_now = loop ? {modem_line_control_reg_q[`MC_OUT2],
                             modem_line_control_reg_q[`MC_RING],
                             modem_line_control_reg_q[`MC_DTR],
                             modem_line_control_reg_q[`MC_RTS]}
                          : {!carrier_detect_n, !ring_indicate_n,
                             !data_set_ready_n, !clear_to_send_n};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modem_prev_q <= 4'h0;
      delta_q      <= 4'h0;
    end else begin
      modem_prev_q <= modem_now;
      delta_q[0] <= (modem_now[0] ^ modem_prev_q[0]) || (delta_q[0] && !rd_mstate);
      delta_q[1] <= (modem_now[1] ^ modem_prev_q[1]) || (delta_q[1] && !rd_mstate);
      delta_q[2] <= (!modem_now[2] && modem_prev_q[2]) || (delta_q[2] && !rd_mstate);
      delta_q[3] <= (modem_now[3] ^ modem_prev_q[3]) || (delta_q[3] && !rd_mstate);
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt priority
  // --------------------------------------------------------------------------
  logic [3:0] src_code;
  logic       line_pend, rx_pend, tx_pend, ms_pend;
  assign line_pend = interrupt_mask_reg_q[2] &
                     (overrun_q | parity_err_q | framing_err_q | break_q);
  assign rx_pend   = interrupt_mask_reg_q[0] & rx_char_waiting_q;
  assign tx_pend   = interrupt_mask_reg_q[1] & tx_irq_q & tx_space_free_q;
  assign ms_pend   = interrupt_mask_reg_q[3] & (|delta_q);
  always_comb begin
    if (line_pend)    src_code = `SRC_LINE;
    else if (rx_pend) src_code = `SRC_RX;
    else if (tx_pend) src_code = `SRC_TX;
    else if (ms_pend) src_code = `SRC_MODEM;
    else              src_code = `SRC_NONE;
  end
  assign tx_irq_clr = rd_src && src_code == `SRC_TX;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_out  <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      irq_out  <= !src_code[0];
      irq_oe_n <= !modem_line_control_reg_q[`MC_OUT2];
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= `RST_BYTE;
    end else if (rd_en) begin
      case (addr)
        `ADDR_DATA:    rdata <= dlab ? divisor_q[7:0] : rx_holding_reg_q;
        `ADDR_MASK:    rdata <= dlab ? divisor_q[15:8] : {4'h0, interrupt_mask_reg_q};
        `ADDR_SOURCE:  rdata <= {4'h0, src_code};
        `ADDR_FORMAT:  rdata <= line_format_reg_q;
        `ADDR_MODEM:   rdata <= modem_line_control_reg_q;
        `ADDR_LINE:    rdata <= {1'b0, tx_space_free_q && tx_state_q == uart_pkg::TX_IDLE,
                                 tx_space_free_q, break_q, framing_err_q,
                                 parity_err_q, overrun_q, rx_char_waiting_q};
        `ADDR_MSTATE:  rdata <= {modem_now, delta_q};
        `ADDR_SCRATCH: rdata <= scratch_q;
        default:       rdata <= `RST_BYTE;
      endcase
    end
  end

endmodule

// [bench/uart_ctl_sva.sv]
// Port checker for the serial channel with register shadows
// Assumes one clock domain and the register map of the design header
`timescale 1ns/1ps
module uart_ctl_sva #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Register port
  input wire logic [2:0]        addr,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  // Pins
  input wire logic              tx_out,
  input wire logic              terminal_ready_n,
  input wire logic              request_to_send_n,
  input wire logic              irq_out,
  input wire logic              irq_oe_n
);
  logic [7:0] lc_q;
  logic [4:0] mc_q;
  logic [3:0] ie_q;
  // ---------------------------------------------------------------------------
  // Register shadows
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lc_q <= 8'h00;
      mc_q <= 5'h00;
      ie_q <= 4'h0;
    end else if (wr_en) begin
      if (addr == 3'h3) lc_q <= wdata[7:0];
      if (addr == 3'h4) mc_q <= wdata[4:0];
      if (addr == 3'h1 && !lc_q[7]) ie_q <= wdata[3:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  dtr_follows_ctl_a: assert property (
    $stable(mc_q) |-> terminal_ready_n == !(mc_q[0] && !mc_q[4]))
    else $error("terminal ready pin wrong");
  rts_follows_ctl_a: assert property (
    $stable(mc_q) |-> request_to_send_n == !(mc_q[1] && !mc_q[4]))
    else $error("request to send pin wrong");
  irq_drive_en_a: assert property (
    $stable(mc_q) |-> irq_oe_n == !mc_q[3]) else $error("interrupt drive enable wrong");
  loop_tx_idle_a: assert property (
    $stable(mc_q) && mc_q[4] && !lc_q[6] |-> tx_out) else $error("tx pin active in loopback");
  break_holds_low_a: assert property (
    $stable(lc_q) && lc_q[6] && !mc_q[4] |-> !tx_out) else $error("break not held");
  masked_irq_quiet_a: assert property (
    (ie_q == 4'h0) [*3] |-> !irq_out) else $error("interrupt while all masked");
  source_code_legal_a: assert property (
    rd_en && addr == 3'h2 |=> rdata[7:4] == 4'h0
      && rdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6}) else $error("bad source code");
  line_top_bits_a: assert property (
    rd_en && addr == 3'h5 |=> !rdata[7] && (!rdata[6] || rdata[5]))
    else $error("line state top bits wrong");
  format_readback_a: assert property (
    rd_en && addr == 3'h3 |=> rdata[7:0] == lc_q) else $error("format readback wrong");
  loop_mirror_a: assert property (
    (mc_q[4] && $stable(mc_q)) [*3] ##0 (rd_en && addr == 3'h6)
      |=> rdata[7:4] == {mc_q[3], mc_q[2], mc_q[0], mc_q[1]})
    else $error("loopback modem state wrong");
endmodule
bind uart_line_and_modem_control uart_ctl_sva #(.DATA_W(DATA_W)) u_sva (
  .clk, .rst_n, .addr, .wr_en, .rd_en, .wdata, .rdata, .tx_out,
  .terminal_ready_n, .request_to_send_n, .irq_out, .irq_oe_n);

// [bench/serial_peer.sv]
// Far-side modem and serial device model
// Assumes a 16-clock bit time, idle-high lines, LSB-first frames
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input  wire logic clk,
  // Serial line
  input  wire logic tx_out,
  output logic      rx_in,
  // Modem lines
  output logic      clear_to_send_n,
  output logic      data_set_ready_n,
  output logic      ring_indicate_n,
  output logic      carrier_detect_n
);
  initial begin
    rx_in = 1'h1;
    {carrier_detect_n, ring_indicate_n, data_set_ready_n, clear_to_send_n} = 4'hf;
  end
  // Frame onto the line, start bit at index 0
  task automatic send(input logic [11:0] f, input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_in <= f[i];
      repeat (16) @(posedge clk);
    end
    rx_in <= 1'h1;
  endtask
  // Modem inputs, order cd ri dsr cts
  task automatic modem(input logic [3:0] m);
    @(posedge clk);
    {carrier_detect_n, ring_indicate_n, data_set_ready_n, clear_to_send_n} <= m;
  endtask
  // Frame from the line, sampled mid-bit
  task automatic grab(output logic [11:0] f, input int n);
    int w;
    f = 12'h000;
    w = 0;
    while (tx_out !== 1'h0 && w < 400) begin
      @(posedge clk);
      w++;
    end
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = tx_out;
      repeat (16) @(posedge clk);
    end
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the serial channel
// Assumes design, checker and far-side model compiled before it
`timescale 1ns/1ps
module tb;
  logic        clk, rst_n, wr_en, rd_en, rx_in, tx_out, irq_out, irq_oe_n;
  logic        clear_to_send_n, data_set_ready_n, ring_indicate_n, carrier_detect_n;
  logic        terminal_ready_n, request_to_send_n;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, v, d;
  logic [11:0] f, g;
  logic [31:0] r;
  int          err_total, total_checks, n;
  int          seed = 32'h2d68;
  uart_line_and_modem_control #(.DATA_W(8)) DUT (.clk, .rst_n, .addr, .wr_en, .rd_en,
    .wdata, .rdata, .rx_in, .tx_out, .clear_to_send_n, .data_set_ready_n,
    .ring_indicate_n, .carrier_detect_n, .terminal_ready_n, .request_to_send_n,
    .irq_out, .irq_oe_n);
  serial_peer peer (.clk, .tx_out, .rx_in, .clear_to_send_n, .data_set_ready_n,
    .ring_indicate_n, .carrier_detect_n);
  initial clk = 1'h0;
  always #5 clk = ~clk;
  // ---------------------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------------------
  task automatic chk(input string s, input logic [11:0] e, input logic [11:0] o);
    total_checks++;
    if (o !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, o);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    @(posedge clk);
    #1 v = rdata;
  endtask
  task automatic settle_rd(input logic [2:0] a, input string s, input logic [7:0] e);
    repeat (6) @(posedge clk);
    rd(a);
    chk(s, {4'h0, e}, {4'h0, v});
  endtask
  function automatic logic [11:0] frame(input logic [7:0] lc, input logic [7:0] x,
                                        output int k);
    logic [7:0] m;
    m = x & (8'hff >> (3 - lc[1:0]));
    frame = {3'h0, m, 1'h0};
    k = 6 + lc[1:0];
    if (lc[3]) begin
      frame[k] = lc[5] ? !lc[4] : (lc[4] ? ^m : ~^m);
      k++;
    end
    frame[k] = 1'h1;
    k++;
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    conclude();
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    {addr, wr_en, rd_en, wdata} = 13'h0000;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    settle_rd(3'h2, "src reset", 8'h01);
    settle_rd(3'h5, "line reset", 8'h60);
    settle_rd(3'h1, "mask reset", 8'h00);
    for (int k = 0; k < 64; k++) begin
      r = $random(seed);
      wr(3'h3, k[7:0]);
      f = frame(k[7:0], r[7:0], n);
      wr(3'h0, r[7:0]);
      fork
        peer.grab(g, n);
        settle_rd(3'h5, "tx busy", 8'h20);
      join
      chk("tx frame", f, g);
      rd(3'h5);
      if (!k[2] || k[1:0] != 2'h0) chk("stop len", k[2] ? 12'h020 : 12'h060, {4'h0, v});
      repeat (30) @(posedge clk);
      d = r[15:8] | {7'h0, r[17]};
      f = frame(k[7:0], d, n);
      if (k[3] && r[16]) f[n-2] = !f[n-2];
      if (r[17]) f[n-1] = 1'h0;
      peer.send(f, n);
      settle_rd(3'h5, "rx status", 8'h61 | {4'h0, r[17], k[3] && r[16], 2'h0});
      settle_rd(3'h0, "rx data", d & (8'hff >> (3 - k[1:0])));
    end
    wr(3'h3, 8'h03);
    f = frame(8'h03, 8'ha5, n);
    peer.send(f, n);
    f = frame(8'h03, 8'h3c, n);
    peer.send(f, n);
    settle_rd(3'h5, "overrun", 8'h63);
    settle_rd(3'h0, "kept data", 8'ha5);
    peer.send(12'h000, 11);
    rd(3'h5);
    chk("break flag", 12'h010, {4'h0, v & 8'h10});
    rd(3'h0);
    wr(3'h1, 8'h0f);
    settle_rd(3'h2, "src tx", 8'h02);
    settle_rd(3'h2, "src none", 8'h01);
    chk("irq idle", 12'h000, {11'h0, irq_out});
    f = frame(8'h03, 8'h81, n);
    f[9] = 1'h0;
    peer.send(f, n);
    settle_rd(3'h2, "src line", 8'h06);
    rd(3'h5);
    settle_rd(3'h2, "src rx", 8'h04);
    rd(3'h0);
    peer.modem(4'he);
    settle_rd(3'h2, "src modem", 8'h00);
    chk("irq up", 12'h001, {11'h0, irq_out});
    settle_rd(3'h6, "cts delta", 8'h11);
    peer.modem(4'ha);
    settle_rd(3'h6, "ri fall", 8'h50);
    peer.modem(4'he);
    settle_rd(3'h6, "ri rise", 8'h14);
    peer.modem(4'h0);
    settle_rd(3'h6, "dsr cd", 8'hfa);
    peer.modem(4'hf);
    settle_rd(3'h6, "all deltas", 8'h0f);
    settle_rd(3'h6, "read clears", 8'h00);
    r = $random(seed);
    peer.modem(r[3:0]);
    settle_rd(3'h6, "rand modem", {~r[3:0], ~r[3], 1'h0, ~r[1:0]});
    wr(3'h4, 8'h1f);
    rd(3'h6);
    settle_rd(3'h6, "loop mirror", 8'hf0);
    wr(3'h0, 8'h5a);
    repeat (200) @(posedge clk);
    settle_rd(3'h5, "loop rx", 8'h61);
    settle_rd(3'h0, "loop data", 8'h5a);
    wr(3'h4, 8'h03);
    repeat (4) @(posedge clk);
    chk("modem pins", 12'h000, {10'h0, terminal_ready_n, request_to_send_n});
    wr(3'h3, 8'h43);
    repeat (4) @(posedge clk);
    chk("break pin", 12'h000, {11'h0, tx_out});
    wr(3'h3, 8'h83);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h03);
    settle_rd(3'h3, "format back", 8'h03);
    settle_rd(3'h1, "mask kept", 8'h0f);
    conclude();
  end
endmodule
